// ===== core/psr_pkg.sv
// Constants, field layouts and carriers for the peripheral soft reset block.
// Assumes an APB completer with 32-bit data, one aligned word per register.
package psr_pkg;

	//--------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------
	localparam logic [11:0] FAST_RST_OFS  = 12'h00c;
	localparam logic [11:0] SLOW_RST_OFS  = 12'h010;
	localparam logic [31:0] FAST_RST_INIT = 32'h0000_0000;
	localparam logic [31:0] SLOW_RST_INIT = 32'h0000_0000;
	localparam logic [31:0] FAST_RW_MASK  = 32'h000e_783d;
	localparam logic [31:0] SLOW_RW_MASK  = 32'hb3e6_0000;

	//--------------------------------------------------------------
	// Fast bus register bit positions
	//--------------------------------------------------------------
	localparam int SPI_B_POS   = 19;
	localparam int UART_E_POS  = 18;
	localparam int UART_D_POS  = 17;
	localparam int USART_A_POS = 14;
	localparam int TIMER_H_POS = 13;
	localparam int SPI_A_POS   = 12;
	localparam int TIMER_A_POS = 11;
	localparam int PORT_D_POS  = 5;
	localparam int PORT_C_POS  = 4;
	localparam int PORT_B_POS  = 3;
	localparam int PORT_A_POS  = 2;
	localparam int ALT_FN_POS  = 0;

	//--------------------------------------------------------------
	// Slow bus register bit positions
	//--------------------------------------------------------------
	localparam int OP_AMP_POS  = 31;
	localparam int DAC_IF_POS  = 29;
	localparam int POWER_POS   = 28;
	localparam int CAN_POS     = 25;
	localparam int USB_CLK_POS = 24;
	localparam int USB_POS     = 23;
	localparam int I2C_B_POS   = 22;
	localparam int I2C_A_POS   = 21;
	localparam int USART_C_POS = 18;
	localparam int USART_B_POS = 17;

	//--------------------------------------------------------------
	// Reset line carriers, one bit per peripheral
	//--------------------------------------------------------------
	typedef struct packed {
		logic spi_b_reset_bit;
		logic uart_e_reset_bit;
		logic uart_d_reset_bit;
		logic usart_a_reset_bit;
		logic timer_h_reset_bit;
		logic spi_a_reset_bit;
		logic timer_a_reset_bit;
		logic port_d_reset_bit;
		logic port_c_reset_bit;
		logic port_b_reset_bit;
		logic port_a_reset_bit;
		logic alt_func_reset_bit;
	} psr_fast_rst_t;

	typedef struct packed {
		logic op_amp_if_reset_bit;
		logic dac_if_reset_bit;
		logic power_if_reset_bit;
		logic can_ctrl_reset_bit;
		logic usb_clk_recovery_reset_bit;
		logic usb_ctrl_reset_bit;
		logic i2c_b_reset_bit;
		logic i2c_a_reset_bit;
		logic usart_c_reset_bit;
		logic usart_b_reset_bit;
	} psr_slow_rst_t;

endpackage

// ===== core/psr_top.sv
// Peripheral soft reset registers with an APB completer port.
// Assumes APB signalling on clk_i; nrst_i is asynchronous, active low.
`timescale 1ns/10ps
module psr_top import psr_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	// APB completer
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [ADDR_W-1:0]   paddr_i,
	input  wire logic [31:0]         pwdata_i,
	input  wire logic [3:0]          pstrb_i,
	output logic                     pready_o,
	output logic                     pslverr_o,
	output logic [31:0]              prdata_o,
	// Peripheral reset lines, high holds reset
	output psr_fast_rst_t            fast_rst_o,
	output psr_slow_rst_t            slow_rst_o
);

	//--------------------------------------------------------------
	// Elaboration checks
	//--------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 12");
	end

	//--------------------------------------------------------------
	// Reset release synchroniser
	//--------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;

	// Two-stage release, assertion stays asynchronous
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	//--------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------
	logic [11:0] addr_full;
	logic        hit_fast;
	logic        hit_slow;
	logic        setup;
	logic        access;
	logic        err_r;
	logic [31:0] strb_mask;

	assign addr_full = 12'(paddr_i);
	assign setup     = psel_i & ~penable_i;
	assign access    = psel_i & penable_i;

	// Only whole aligned words are mapped
	always_comb begin
		hit_fast = 1'b0;
		hit_slow = 1'b0;
		if (addr_full == FAST_RST_OFS) begin
			hit_fast = 1'b1;
		end else if (addr_full == SLOW_RST_OFS) begin
			hit_slow = 1'b1;
		end
	end

	// Byte lane enables widened to bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strb_mask[i*8 +: 8] = {8{pstrb_i[i]}};
		end
	end

	//--------------------------------------------------------------
	// Register storage
	//--------------------------------------------------------------
	logic [31:0] fast_r;
	logic [31:0] slow_r;
	logic [31:0] fast_nxt;
	logic [31:0] slow_nxt;
	logic        wr_fire;

	assign wr_fire = access & pwrite_i & ~err_r;

	always_comb begin
		fast_nxt = (fast_r & ~strb_mask) | (pwdata_i & strb_mask);
		slow_nxt = (slow_r & ~strb_mask) | (pwdata_i & strb_mask);
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fast_r <= FAST_RST_INIT;
		end else if (wr_fire && hit_fast) begin
			fast_r <= fast_nxt & FAST_RW_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			slow_r <= SLOW_RST_INIT;
		end else if (wr_fire && hit_slow) begin
			slow_r <= slow_nxt & SLOW_RW_MASK;
		end
	end

	//--------------------------------------------------------------
	// APB answer
	//--------------------------------------------------------------
	// Error and read data captured in setup phase
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			err_r <= 1'b0;
		end else if (setup) begin
			err_r <= ~(hit_fast | hit_slow);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup && !pwrite_i) begin
			if (hit_fast) begin
				prdata_o <= fast_r;
			end else if (hit_slow) begin
				prdata_o <= slow_r;
			end else begin
				prdata_o <= 32'h0000_0000;
			end
		end
	end

	assign pready_o  = 1'b1;             // No wait states
	assign pslverr_o = access & err_r;   // Unmapped address

	//--------------------------------------------------------------
	// Reset line fan-out
	//--------------------------------------------------------------
	// fast bus peripheral lines
	always_comb begin
		fast_rst_o.spi_b_reset_bit    = fast_r[SPI_B_POS];
		fast_rst_o.uart_e_reset_bit   = fast_r[UART_E_POS];
		fast_rst_o.uart_d_reset_bit   = fast_r[UART_D_POS];
		fast_rst_o.usart_a_reset_bit  = fast_r[USART_A_POS];
		fast_rst_o.timer_h_reset_bit  = fast_r[TIMER_H_POS];
		fast_rst_o.spi_a_reset_bit    = fast_r[SPI_A_POS];
		fast_rst_o.timer_a_reset_bit  = fast_r[TIMER_A_POS];
		fast_rst_o.port_d_reset_bit   = fast_r[PORT_D_POS];
		fast_rst_o.port_c_reset_bit   = fast_r[PORT_C_POS];
		fast_rst_o.port_b_reset_bit   = fast_r[PORT_B_POS];
		fast_rst_o.port_a_reset_bit   = fast_r[PORT_A_POS];
		fast_rst_o.alt_func_reset_bit = fast_r[ALT_FN_POS];
	end

	always_comb begin
		slow_rst_o.op_amp_if_reset_bit        = slow_r[OP_AMP_POS];
		slow_rst_o.dac_if_reset_bit           = slow_r[DAC_IF_POS];
		slow_rst_o.power_if_reset_bit         = slow_r[POWER_POS];
		slow_rst_o.can_ctrl_reset_bit         = slow_r[CAN_POS];
		slow_rst_o.usb_clk_recovery_reset_bit = slow_r[USB_CLK_POS];
		slow_rst_o.usb_ctrl_reset_bit         = slow_r[USB_POS];
		slow_rst_o.i2c_b_reset_bit            = slow_r[I2C_B_POS];
		slow_rst_o.i2c_a_reset_bit            = slow_r[I2C_A_POS];
		slow_rst_o.usart_c_reset_bit          = slow_r[USART_C_POS];
		slow_rst_o.usart_b_reset_bit          = slow_r[USART_B_POS];
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	sequence s_full_write(logic [11:0] ofs);
		psel_i && penable_i && pwrite_i && pstrb_i == 4'hf && addr_full == ofs;
	endsequence

	sequence s_read_setup(logic [11:0] ofs);
		psel_i && !penable_i && !pwrite_i && addr_full == ofs;
	endsequence

	chk_fast_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(FAST_RST_OFS) |=> fast_r == ($past(pwdata_i) & FAST_RW_MASK))
		else $error("fast register did not take written value");

	chk_slow_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(SLOW_RST_OFS) |=> slow_r == ($past(pwdata_i) & SLOW_RW_MASK))
		else $error("slow register did not take written value");

	chk_read_returns_fast: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_read_setup(FAST_RST_OFS) ##1 (psel_i && penable_i)
		|-> prdata_o == fast_r && !pslverr_o)
		else $error("fast register read mismatch");

	chk_fast_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		(fast_r & ~FAST_RW_MASK) == 32'h0000_0000)
		else $error("fast reserved bit set");

	chk_slow_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		(slow_r & ~SLOW_RW_MASK) == 32'h0000_0000)
		else $error("slow reserved bit set");

	chk_slow_after_reset: assert property (@(posedge clk_i)
		$rose(rst_n) |-> slow_r == 32'h0000_0000 && slow_rst_o == '0)
		else $error("slow register not zero after reset");

	chk_port_lines: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(FAST_RST_OFS) |=> $past(pwdata_i[PORT_D_POS:PORT_A_POS]) ==
		{fast_rst_o.port_d_reset_bit, fast_rst_o.port_c_reset_bit,
		 fast_rst_o.port_b_reset_bit, fast_rst_o.port_a_reset_bit})
		else $error("port reset lines not following write");

	chk_alt_func_line: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(FAST_RST_OFS) |=> fast_rst_o.alt_func_reset_bit == $past(pwdata_i[0]))
		else $error("alternate function line not following write");

	chk_dac_line_holds: assert property (@(posedge clk_i) disable iff (!rst_n)
		!(psel_i && penable_i && pwrite_i) |=> $stable(slow_rst_o.dac_if_reset_bit))
		else $error("converter line changed without write");

	chk_op_amp_line: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(SLOW_RST_OFS) |=> slow_rst_o.op_amp_if_reset_bit == $past(pwdata_i[31]))
		else $error("op-amp line not following write");

	chk_usart_b_line: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(SLOW_RST_OFS) |=> slow_rst_o.usart_b_reset_bit == $past(pwdata_i[17]))
		else $error("second USART line not following write");

	chk_unmapped_err: assert property (@(posedge clk_i) disable iff (!rst_n)
		psel_i && !penable_i && addr_full != FAST_RST_OFS && addr_full != SLOW_RST_OFS
		##1 psel_i && penable_i |-> pslverr_o)
		else $error("unmapped access not refused");

	//--------------------------------------------------------------
	// Assertion helpers and bus behaviour checks
	//--------------------------------------------------------------
	psr_fast_rst_t wdata_fast;
	psr_slow_rst_t wdata_slow;

	// Write data gathered into fast carrier order
	always_comb begin
		wdata_fast.spi_b_reset_bit    = pwdata_i[SPI_B_POS];
		wdata_fast.uart_e_reset_bit   = pwdata_i[UART_E_POS];
		wdata_fast.uart_d_reset_bit   = pwdata_i[UART_D_POS];
		wdata_fast.usart_a_reset_bit  = pwdata_i[USART_A_POS];
		wdata_fast.timer_h_reset_bit  = pwdata_i[TIMER_H_POS];
		wdata_fast.spi_a_reset_bit    = pwdata_i[SPI_A_POS];
		wdata_fast.timer_a_reset_bit  = pwdata_i[TIMER_A_POS];
		wdata_fast.port_d_reset_bit   = pwdata_i[PORT_D_POS];
		wdata_fast.port_c_reset_bit   = pwdata_i[PORT_C_POS];
		wdata_fast.port_b_reset_bit   = pwdata_i[PORT_B_POS];
		wdata_fast.port_a_reset_bit   = pwdata_i[PORT_A_POS];
		wdata_fast.alt_func_reset_bit = pwdata_i[ALT_FN_POS];
	end

	// Write data gathered into slow carrier order
	always_comb begin
		wdata_slow.op_amp_if_reset_bit        = pwdata_i[OP_AMP_POS];
		wdata_slow.dac_if_reset_bit           = pwdata_i[DAC_IF_POS];
		wdata_slow.power_if_reset_bit         = pwdata_i[POWER_POS];
		wdata_slow.can_ctrl_reset_bit         = pwdata_i[CAN_POS];
		wdata_slow.usb_clk_recovery_reset_bit = pwdata_i[USB_CLK_POS];
		wdata_slow.usb_ctrl_reset_bit         = pwdata_i[USB_POS];
		wdata_slow.i2c_b_reset_bit            = pwdata_i[I2C_B_POS];
		wdata_slow.i2c_a_reset_bit            = pwdata_i[I2C_A_POS];
		wdata_slow.usart_c_reset_bit          = pwdata_i[USART_C_POS];
		wdata_slow.usart_b_reset_bit          = pwdata_i[USART_B_POS];
	end

	sequence s_access;
		psel_i && penable_i;
	endsequence

	sequence s_write_setup(logic [11:0] ofs);
		psel_i && !penable_i && pwrite_i && addr_full == ofs;
	endsequence

	sequence s_unmapped_setup;
		psel_i && !penable_i && addr_full != FAST_RST_OFS && addr_full != SLOW_RST_OFS;
	endsequence

	chk_fast_lines_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(FAST_RST_OFS) |=> fast_rst_o == $past(wdata_fast))
		else $error("fast reset lines not following write");

	chk_slow_lines_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_full_write(SLOW_RST_OFS) |=> slow_rst_o == $past(wdata_slow))
		else $error("slow reset lines not following write");

	chk_fast_lanes_kept: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_write_setup(FAST_RST_OFS) ##1 s_access
		|=> ((fast_r ^ $past(fast_r)) & ~$past(strb_mask)) == 32'h0000_0000)
		else $error("fast register changed in a disabled lane");

	chk_slow_lanes_kept: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_write_setup(SLOW_RST_OFS) ##1 s_access
		|=> ((slow_r ^ $past(slow_r)) & ~$past(strb_mask)) == 32'h0000_0000)
		else $error("slow register changed in a disabled lane");

	chk_read_returns_slow: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_read_setup(SLOW_RST_OFS) ##1 s_access
		|-> prdata_o == slow_r && !pslverr_o)
		else $error("slow register read mismatch");

	chk_write_no_err: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_write_setup(FAST_RST_OFS) ##1 s_access |-> !pslverr_o)
		else $error("mapped write refused");

	chk_lines_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
		!(psel_i && penable_i && pwrite_i) |=> $stable(fast_rst_o) && $stable(slow_rst_o))
		else $error("reset lines changed without write");

	chk_unmapped_wr_kept: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_unmapped_setup ##1 s_access |=> $stable(fast_r) && $stable(slow_r))
		else $error("unmapped access changed a register");

	chk_unmapped_rd_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_unmapped_setup ##1 (psel_i && penable_i && !pwrite_i)
		|-> prdata_o == 32'h0000_0000)
		else $error("unmapped read returned data");

	chk_err_only_access: assert property (@(posedge clk_i) disable iff (!rst_n)
		!(psel_i && penable_i) |-> !pslverr_o)
		else $error("error response outside access phase");

	chk_fast_after_reset: assert property (@(posedge clk_i)
		$rose(rst_n) |-> fast_r == FAST_RST_INIT && fast_rst_o == '0)
		else $error("fast register not zero after reset");

endmodule // psr_top

// ===== tb/testbench.sv
// Self-checking bench for the peripheral soft reset registers.
// Assumes psr_top with default ADDR_W; drives the APB side directly.
`timescale 1ns/10ps
module testbench import psr_pkg::*;;

	//------------------------------------------------------------------
	// Signals and bookkeeping
	//------------------------------------------------------------------
	logic          clk_i, nrst_i, psel_i, penable_i, pwrite_i;
	logic [11:0]   paddr_i;
	logic [31:0]   pwdata_i, prdata_o, fast_m, slow_m, rd;
	logic [3:0]    pstrb_i;
	logic          pready_o, pslverr_o, er;
	psr_fast_rst_t fast_rst_o;
	psr_slow_rst_t slow_rst_o;
	int            miscompares, n_compared, i;
	int            seed = 32'he75390b8;
	logic [11:0]   bad_a [3] = '{12'h000, 12'h014, 12'h00d};

	psr_top i_psr_top (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
		.fast_rst_o(fast_rst_o), .slow_rst_o(slow_rst_o));

	// Clock at 100 MHz
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	task automatic wrap_up;
		$display("Compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Expected reset lines from a register word
	function automatic psr_fast_rst_t fast_lines(input logic [31:0] r);
		return {r[SPI_B_POS], r[UART_E_POS], r[UART_D_POS], r[USART_A_POS], r[TIMER_H_POS],
			r[SPI_A_POS], r[TIMER_A_POS], r[PORT_D_POS], r[PORT_C_POS], r[PORT_B_POS],
			r[PORT_A_POS], r[ALT_FN_POS]};
	endfunction

	function automatic psr_slow_rst_t slow_lines(input logic [31:0] r);
		return {r[OP_AMP_POS], r[DAC_IF_POS], r[POWER_POS], r[CAN_POS], r[USB_CLK_POS],
			r[USB_POS], r[I2C_B_POS], r[I2C_A_POS], r[USART_C_POS], r[USART_B_POS]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, d, m, input logic [3:0] s);
		logic [31:0] l;
		l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return ((o & ~l) | (d & l)) & m;
	endfunction

	// One APB transfer; leaves psel up so another may follow at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 50) begin
				miscompares++;
				wrap_up();
			end
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s);
		if (a == FAST_RST_OFS)
			fast_m = merge(fast_m, d, FAST_RW_MASK, s);
		if (a == SLOW_RST_OFS)
			slow_m = merge(slow_m, d, SLOW_RW_MASK, s);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		check("read data", rd, exp);
		check("slave error", {31'h0, er}, {31'h0, e});
	endtask

	task automatic idle;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Reset lines and both registers against the model
	task automatic check_all;
		idle();
		idle();
		check("fast lines", {20'h0, fast_rst_o}, {20'h0, fast_lines(fast_m)});
		check("slow lines", {22'h0, slow_rst_o}, {22'h0, slow_lines(slow_m)});
		rd_chk(FAST_RST_OFS, fast_m, 1'b0);
		rd_chk(SLOW_RST_OFS, slow_m, 1'b0);
		idle();
	endtask

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
		fast_m = FAST_RST_INIT;
		slow_m = SLOW_RST_INIT;
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check_all();
		wr(FAST_RST_OFS, 32'hffff_ffff, 4'hf);
		wr(SLOW_RST_OFS, 32'hffff_ffff, 4'hf);
		check_all();
		wr(FAST_RST_OFS, 32'h0000_0000, 4'hf);
		wr(SLOW_RST_OFS, 32'h0000_0000, 4'hf);
		check_all();
		for (i = 0; i < 32; i++) begin
			wr(FAST_RST_OFS, 32'h1 << i, 4'hf);
			wr(SLOW_RST_OFS, 32'h1 << i, 4'hf);
			check_all();
		end
		// random data keeps reserved fields at zero, random lanes
		repeat (40) begin
			if ($random(seed) & 1)
				wr(FAST_RST_OFS, $random(seed) & FAST_RW_MASK, 4'($random(seed)));
			else
				wr(SLOW_RST_OFS, $random(seed) & SLOW_RW_MASK, 4'($random(seed)));
			check_all();
		end
		// Unmapped addresses leave both registers alone
		foreach (bad_a[k]) begin
			wr(bad_a[k], 32'hffff_ffff, 4'hf);
			rd_chk(bad_a[k], 32'h0000_0000, 1'b1);
		end
		check_all();
		wr(FAST_RST_OFS, 32'hffff_ffff, 4'hf);
		wr(SLOW_RST_OFS, 32'hffff_ffff, 4'hf);
		idle();
		nrst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("fast lines in reset", {20'h0, fast_rst_o}, 32'h0);
		check("slow lines in reset", {22'h0, slow_rst_o}, 32'h0);
		@(posedge clk_i);
		nrst_i <= 1'b1;
		fast_m = FAST_RST_INIT;
		slow_m = SLOW_RST_INIT;
		repeat (3) @(posedge clk_i);
		check_all();
		wrap_up();
	end

	// Watchdog for the whole run
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		wrap_up();
	end

endmodule // testbench
